//--- lws_pkg.sv
//==============================================================
// shared constants and state layout
//==============================================================
package lws_pkg;

    //==============================================================
    // bus geometry
    //==============================================================
    localparam int ADDR_W = 17;                  // word address width
    localparam int LANE_W = 9;                   // one byte lane is nine bits
    localparam int LANES = 4;                    // lanes across the word
    localparam int DATA_W = LANE_W * LANES;      // full word width
    localparam int DEPTH = 1 << ADDR_W;          // words in the array

    //==============================================================
    // reset values and lane masks
    //==============================================================
    localparam logic [DATA_W-1:0] DOUT_RST = 36'h0_0000_0000;  // output latch after reset
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;       // address fields after reset
    localparam logic [LANES-1:0] LANE_NONE = 4'h0;             // no lane enabled
    localparam logic [LANES-1:0] LANE_ALL = 4'hF;              // every lane enabled

    //==============================================================
    // power-up dwell the host keeps before first access
    //==============================================================
    localparam int DWELL_NS = 1000000;           // 1.0 ms in ns
    localparam int CLK_PERIOD_NS = 5;            // clk_sys period
    localparam int DWELL_CYCLES = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    //==============================================================
    // all registered state of the core apart from the storage array
    //==============================================================
    typedef struct packed {
        logic [DATA_W-1:0] dout;                 // output latch
        logic drive;                             // registered output drive
        logic wa_pend;                           // write address taken, data due
        logic [ADDR_W-1:0] wa_addr;              // address of that write
        logic [LANES-1:0] wa_be;                 // lanes of that write
        logic buf_valid;                         // buffer holds an uncommitted write
        logic [ADDR_W-1:0] buf_addr;             // buffered write address
        logic [LANES-1:0] buf_be;                // buffered write lanes
        logic [DATA_W-1:0] buf_data;             // buffered write data
    } lws_state_s;

endpackage : lws_pkg

//--- lws_core.sv
`timescale 1ns/1ps
//==============================================================
// late write synchronous static ram core
//==============================================================
// Notes on behaviour
// RULE1: address and controls registered on rising edge
// RULE2: read data presented in capture cycle
// RULE3: read data held until next read
// RULE4: back to back reads, one per clock
// RULE5: read allowed directly after a write
// RULE6: deselect turns drivers off same cycle
// RULE7: write turns drivers off same cycle
// RULE8: read enables drivers after capture edge
// RULE9: output enable gates drivers without clock
// RULE10: byte lanes are nine bits wide
// RULE11: reads ignore lane enables, return all
// RULE12: writes update only enabled lanes
// RULE13: any write cycle performs no read
// RULE14: write with no lanes changes nothing
// RULE15: write data taken one edge after address
// RULE16: one-entry buffer forwards matching bytes
// RULE17: host waits power-up dwell before use
// RULE18: host changes controls once per clock
// RULE19: lane n covers bits 9n to 9n+8
// RULE20: buffer commits when next write accepted
module lws_core (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [lws_pkg::ADDR_W-1:0] addr,
    input wire logic chip_select_n,
    input wire logic sync_write_n,
    input wire logic lane0_write_enable_n,
    input wire logic lane1_write_enable_n,
    input wire logic lane2_write_enable_n,
    input wire logic lane3_write_enable_n,
    input wire logic output_enable_n,
    input wire logic [lws_pkg::DATA_W-1:0] dq_in,
    output logic [lws_pkg::DATA_W-1:0] dq_out,
    output logic [lws_pkg::DATA_W-1:0] dq_oe
);

    //==============================================================
    // declarations
    //==============================================================
    lws_pkg::lws_state_s st;                     // registered state
    lws_pkg::lws_state_s next_st;                // next state
    logic [lws_pkg::DATA_W-1:0] mem [0:lws_pkg::DEPTH-1];  // storage array
    logic [lws_pkg::LANES-1:0] lane_en;          // active-high lane enables
    logic rd_req;                                // read sampled this edge
    logic wr_req;                                // write sampled this edge
    logic [lws_pkg::DATA_W-1:0] mem_word;        // raw array word at addr
    logic [lws_pkg::DATA_W-1:0] rd_data;         // word after forwarding
    logic hit_wa;                                // read hits write awaiting data
    logic hit_buf;                               // read hits buffered write

    //==============================================================
    // request decode
    //==============================================================
    // lane 0 is the lowest nine bits
    assign lane_en = ~{lane3_write_enable_n, lane2_write_enable_n,
                       lane1_write_enable_n, lane0_write_enable_n};  // RULE19
    // controls act only as sampled at the edge
    assign rd_req = !chip_select_n && sync_write_n;    // RULE1
    assign wr_req = !chip_select_n && !sync_write_n;   // RULE1

    //==============================================================
    // read path with buffer forwarding
    //==============================================================
    assign mem_word = mem[addr];
    assign hit_wa = st.wa_pend && (addr == st.wa_addr);
    assign hit_buf = st.buf_valid && (addr == st.buf_addr);

    // per lane: newest pending data wins, then buffer, then array
    genvar gi;
    generate
        for (gi = 0; gi < lws_pkg::LANES; gi++) begin : g_lane
            always_comb begin
                if (hit_wa && st.wa_be[gi]) begin
                    // data of the write arriving at this very edge
                    rd_data[gi*lws_pkg::LANE_W +: lws_pkg::LANE_W] =
                        dq_in[gi*lws_pkg::LANE_W +: lws_pkg::LANE_W];  // RULE16
                end else if (hit_buf && st.buf_be[gi]) begin
                    // buffered bytes not yet in the array
                    rd_data[gi*lws_pkg::LANE_W +: lws_pkg::LANE_W] =
                        st.buf_data[gi*lws_pkg::LANE_W +: lws_pkg::LANE_W];  // RULE16
                end else begin
                    // plain array lane
                    rd_data[gi*lws_pkg::LANE_W +: lws_pkg::LANE_W] =
                        mem_word[gi*lws_pkg::LANE_W +: lws_pkg::LANE_W];  // RULE10
                end
            end
        end
    endgenerate

    //==============================================================
    // next state
    //==============================================================
    always_comb begin
        next_st = st;
        // output drive and latch
        if (rd_req) begin
            // every lane returned, lane enables ignored
            next_st.dout = rd_data;              // RULE2 RULE11
            next_st.drive = 1'b1;                // RULE8 RULE4 RULE5
        end else if (wr_req) begin
            // no read of any lane in a write cycle
            next_st.drive = 1'b0;                // RULE7 RULE13 RULE14
        end else begin
            // deselect
            next_st.drive = 1'b0;                // RULE6
        end
        // late data of the previous write lands in the buffer
        if (st.wa_pend) begin
            next_st.buf_valid = (st.wa_be != lws_pkg::LANE_NONE);  // RULE14
            next_st.buf_addr = st.wa_addr;       // RULE15
            next_st.buf_be = st.wa_be;           // RULE12
            next_st.buf_data = dq_in;            // RULE15
        end else if (wr_req) begin
            // buffer is committed to the array at this edge
            next_st.buf_valid = 1'b0;            // RULE20
        end
        // write address stage
        if (wr_req) begin
            next_st.wa_pend = 1'b1;              // RULE15
            next_st.wa_addr = addr;              // RULE1
            next_st.wa_be = lane_en;             // RULE10 RULE12
        end else begin
            next_st.wa_pend = 1'b0;
        end
    end

    //==============================================================
    // state register
    //==============================================================
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st.dout <= lws_pkg::DOUT_RST;
            st.drive <= 1'b0;
            st.wa_pend <= 1'b0;
            st.wa_addr <= lws_pkg::ADDR_RST;
            st.wa_be <= lws_pkg::LANE_NONE;
            st.buf_valid <= 1'b0;
            st.buf_addr <= lws_pkg::ADDR_RST;
            st.buf_be <= lws_pkg::LANE_NONE;
            st.buf_data <= lws_pkg::DOUT_RST;
        end else begin
            st <= next_st;
        end
    end

    //==============================================================
    // array commit
    //==============================================================
    // the old buffer goes to the array when a new write is taken
    always_ff @(posedge clk_sys) begin
        if (wr_req && st.buf_valid && !st.wa_pend) begin
            for (int i = 0; i < lws_pkg::LANES; i++) begin
                if (st.buf_be[i]) begin
                    mem[st.buf_addr][i*lws_pkg::LANE_W +: lws_pkg::LANE_W] <=
                        st.buf_data[i*lws_pkg::LANE_W +: lws_pkg::LANE_W];  // RULE20 RULE12
                end
            end
        end else if (st.wa_pend && st.buf_valid) begin
            // back to back write: buffer is replaced, so commit it now
            for (int i = 0; i < lws_pkg::LANES; i++) begin
                if (st.buf_be[i]) begin
                    mem[st.buf_addr][i*lws_pkg::LANE_W +: lws_pkg::LANE_W] <=
                        st.buf_data[i*lws_pkg::LANE_W +: lws_pkg::LANE_W];  // RULE20
                end
            end
        end
    end

    //==============================================================
    // pins
    //==============================================================
    assign dq_out = st.dout;                     // RULE3
    // asynchronous gate, no clock edge involved
    assign dq_oe = {lws_pkg::DATA_W{st.drive & ~output_enable_n}};  // RULE9

    //==============================================================
    // checks
    //==============================================================
    // read of a word held whole in the buffer, no newer write to it pending
    logic rd_hit_full;
    assign rd_hit_full = rd_req && hit_buf && !hit_wa && (st.buf_be == lws_pkg::LANE_ALL);
    // read meeting a full write whose data arrives at this very edge
    logic rd_hit_wa_full;
    assign rd_hit_wa_full = rd_req && hit_wa && (st.wa_be == lws_pkg::LANE_ALL);

    //==============================================================
    // output drive checks
    //==============================================================
    // deselect drops the drivers at once
    a_deselect_off: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE6
        chip_select_n |=> (dq_oe == '0))
        else $error("drivers on after deselect");

    // deselect leaves the latch alone
    a_deselect_hold: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE6
        chip_select_n |=> $stable(dq_out))
        else $error("latch changed in deselect cycle");

    // write drops the drivers and reads nothing
    a_write_off: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE7 RULE13
        wr_req |=> (dq_oe == '0) && $stable(dq_out))
        else $error("drivers on or latch changed in write cycle");

    // abort write still drops the drivers
    a_abort_oe: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE14
        wr_req && (lane_en == lws_pkg::LANE_NONE) |=> (dq_oe == '0))
        else $error("drivers on after abort write");

    // selected read turns the drivers on
    a_read_drive: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE8
        rd_req && !output_enable_n |=> (dq_oe == '1) || output_enable_n)
        else $error("read did not enable drivers");

    // drive only ever follows a read edge
    a_drive_read: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE8
        st.drive |-> $past(rd_req))
        else $error("drivers on without a read");

    // lane enables do not stop a read
    a_lane_ignore: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE11
        rd_req && (lane_en != lws_pkg::LANE_ALL) |=> st.drive)
        else $error("read with lane enables not driven");

    // output enable gates without a clock
    a_oe_gate: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE9
        output_enable_n |-> (dq_oe == '0))
        else $error("output enable did not gate drivers");

    //==============================================================
    // output latch checks
    //==============================================================
    // latch moves only on a read edge
    a_data_hold: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE3
        !rd_req |=> $stable(dq_out))
        else $error("output latch moved without a read");

    // read loads the forwarded word
    a_read_latch: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE2
        rd_req |=> (dq_out == $past(rd_data)))
        else $error("read word not latched");

    // one read per clock, back to back
    a_reads_b2b: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE4
        rd_req ##1 rd_req |=> st.drive)
        else $error("second back to back read not driven");

    //==============================================================
    // write path checks
    //==============================================================
    // write address and lanes taken at the edge
    a_wa_capture: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE1
        wr_req |=> st.wa_pend && (st.wa_addr == $past(addr))
        && (st.wa_be == $past(lane_en)))
        else $error("write address or lanes not captured");

    // no write, nothing awaits data
    a_no_wa_idle: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE15
        !wr_req |=> !st.wa_pend)
        else $error("write pending without a write");

    // data lands one edge after its address
    a_late_data: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE15
        wr_req && (lane_en != lws_pkg::LANE_NONE) |=> ##1
        st.buf_valid && (st.buf_addr == $past(addr, 2)) && (st.buf_data == $past(dq_in)))
        else $error("write data not taken one edge after address");

    // buffered lanes are the sampled lanes
    a_lane_mask: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE12
        wr_req |=> ##1 (st.buf_be == $past(lane_en, 2)))
        else $error("buffered lanes differ from sampled enables");

    // abort write leaves no entry
    a_abort_write: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE14
        wr_req && (lane_en == lws_pkg::LANE_NONE) |=> ##1 !st.buf_valid)
        else $error("abort write left a buffered entry");

    // buffer address follows the pending address
    a_buf_addr: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE15
        st.wa_pend |=> (st.buf_addr == $past(st.wa_addr)))
        else $error("buffer address not the pending address");

    // buffer data is the bus one edge late
    a_buf_data: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE15
        st.wa_pend |=> (st.buf_data == $past(dq_in)))
        else $error("buffer data not the late write data");

    // new write commits the old entry
    a_one_pending: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE20
        wr_req && !st.wa_pend |=> !st.buf_valid)
        else $error("old buffer entry kept past a new write");

    // reads with no write pending leave the buffer alone
    a_read_keeps_buf: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE16
        rd_req && !st.wa_pend |=> $stable(st.buf_valid))
        else $error("read changed buffer state");

    //==============================================================
    // forwarding checks
    //==============================================================
    // whole buffered word forwarded
    a_forward_buf: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE16
        rd_hit_full |=> (dq_out == $past(st.buf_data)))
        else $error("buffered word not forwarded");

    // word arriving on the bus forwarded
    a_fwd_pending: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE16
        rd_hit_wa_full |=> (dq_out == $past(dq_in)))
        else $error("arriving write word not forwarded");

    // lowest lane sits on the lowest nine bits
    a_lane_map: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE19
        rd_req && hit_wa && st.wa_be[0] |=> (dq_out[lws_pkg::LANE_W-1:0] == $past(dq_in[lws_pkg::LANE_W-1:0])))
        else $error("lowest lane on wrong bits");

    // top lane sits on the top nine bits
    a_lane_top: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE19
        rd_req && hit_wa && st.wa_be[lws_pkg::LANES-1] |=>
        (dq_out[lws_pkg::DATA_W-1 -: lws_pkg::LANE_W] == $past(dq_in[lws_pkg::DATA_W-1 -: lws_pkg::LANE_W])))
        else $error("top lane on wrong bits");

    //==============================================================
    // scenario covers
    //==============================================================
    // three reads in a row
    c_read_b2b: cover property (@(posedge clk_sys) disable iff (!rstn)
        rd_req ##1 rd_req ##1 rd_req);
    // read straight after a write to it
    c_write_read: cover property (@(posedge clk_sys) disable iff (!rstn)
        wr_req ##1 (rd_req && hit_wa));
    // partial lane write
    c_byte_write: cover property (@(posedge clk_sys) disable iff (!rstn)
        wr_req && (lane_en != lws_pkg::LANE_ALL) && (lane_en != lws_pkg::LANE_NONE));
    // read served from the buffer
    c_buf_hit: cover property (@(posedge clk_sys) disable iff (!rstn)
        rd_req && hit_buf);
    // write with no lane enabled
    c_abort_write: cover property (@(posedge clk_sys) disable iff (!rstn)
        wr_req && (lane_en == lws_pkg::LANE_NONE));

endmodule : lws_core

//--- lws_host.sv
`timescale 1ns/1ps
//==============================================================
// host side model: drives address, controls and late data
//==============================================================
module lws_host #(
    parameter int DWELL = 20  // shortened power-up dwell in cycles
) (
    input wire logic clk_sys,
    output logic [lws_pkg::ADDR_W-1:0] addr,
    output logic chip_select_n,
    output logic sync_write_n,
    output logic [lws_pkg::LANES-1:0] lane_n,
    output logic output_enable_n,
    output logic [lws_pkg::DATA_W-1:0] dq_in
);
    logic data_due;                        // last cycle issued a write
    logic [lws_pkg::DATA_W-1:0] due_data;  // data owed for that write

    // idle bus at time zero
    initial begin
        addr = 17'h0_0000;
        chip_select_n = 1'b1;
        sync_write_n = 1'b1;
        lane_n = 4'hF;
        output_enable_n = 1'b0;
        dq_in = 36'h0_0000_0000;
        data_due = 1'b0;
        due_data = 36'h0_0000_0000;
    end

    // one bus cycle, all inputs but output enable change once just after the edge
    task automatic cyc(input logic cs_n, input logic wr_n, input logic [3:0] ln_n,
                       input logic [16:0] a, input logic [35:0] d);
        @(posedge clk_sys);
        addr <= a;
        chip_select_n <= cs_n;
        sync_write_n <= wr_n;
        lane_n <= ln_n;
        // late data one cycle after its address, else a changing pattern
        dq_in <= data_due ? due_data : ~dq_in;
        data_due = !cs_n && !wr_n;
        due_data = d;
    endtask : cyc

    // clock keeps running before the first real access
    task automatic dwell();
        repeat (DWELL) @(posedge clk_sys);
    endtask : dwell
endmodule : lws_host

//--- late_write_sync_sram_core_tb_top.sv
`timescale 1ns/1ps
//==============================================================
// testbench top
//==============================================================
module late_write_sync_sram_core_tb_top;
    localparam logic [35:0] D1 = 36'hA_5A5A_5A5A;    // first word
    localparam logic [35:0] D2 = 36'h3_C3C3_C3C3;    // second word
    localparam logic [35:0] M1 = 36'h0_0003_FE00;    // lane1 bits 17:9
    localparam logic [35:0] ONES = 36'hF_FFFF_FFFF;  // drivers on
    localparam logic [35:0] ZERO = 36'h0_0000_0000;  // drivers off
    localparam logic [16:0] A = 17'h0_0010;          // test address
    localparam logic [16:0] B = 17'h1_FFFF;          // top address
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [16:0] addr;
    logic chip_select_n, sync_write_n, output_enable_n;
    logic [3:0] lane_n;
    logic [35:0] dq_in, dq_out, dq_oe;
    logic [35:0] merged;  // word at A after lane1 write
    int mismatches = 0;
    int checks = 0;

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    lws_host host (.clk_sys(clk_sys), .addr(addr), .chip_select_n(chip_select_n),
        .sync_write_n(sync_write_n), .lane_n(lane_n), .output_enable_n(output_enable_n), .dq_in(dq_in));
    lws_core DUT (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .chip_select_n(chip_select_n),
        .sync_write_n(sync_write_n), .lane0_write_enable_n(lane_n[0]), .lane1_write_enable_n(lane_n[1]),
        .lane2_write_enable_n(lane_n[2]), .lane3_write_enable_n(lane_n[3]),
        .output_enable_n(output_enable_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    // compare and count
    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // full write then read at once, then deselect
    task automatic t_write_read();
        host.cyc(1'b0, 1'b0, 4'h0, A, D1);
        host.cyc(1'b0, 1'b1, 4'hF, A, ZERO);
        @(negedge clk_sys) chk("oe after write", dq_oe, ZERO);
        host.cyc(1'b1, 1'b1, 4'hF, A, ZERO);
        @(negedge clk_sys) chk("forwarded read", dq_out, D1);
        chk("oe on read", dq_oe, ONES);
        host.cyc(1'b1, 1'b1, 4'hF, A, ZERO);
        @(negedge clk_sys) chk("oe deselect", dq_oe, ZERO);
        chk("data held", dq_out, D1);
    endtask : t_write_read

    // lane1 write, second write commits it, back to back reads
    task automatic t_byte_merge();
        host.cyc(1'b0, 1'b0, 4'hD, A, D2);
        host.cyc(1'b0, 1'b0, 4'h0, B, D1);
        host.cyc(1'b0, 1'b1, 4'h0, A, ZERO);
        host.cyc(1'b0, 1'b1, 4'hF, B, ZERO);
        @(negedge clk_sys) chk("lane merge", dq_out, merged);
        host.cyc(1'b1, 1'b1, 4'hF, A, ZERO);
        @(negedge clk_sys) chk("second read", dq_out, D1);
    endtask : t_byte_merge

    // write with no lane enabled changes nothing
    task automatic t_abort();
        host.cyc(1'b0, 1'b0, 4'hF, A, D2);
        host.cyc(1'b0, 1'b1, 4'hF, A, ZERO);
        @(negedge clk_sys) chk("oe abort", dq_oe, ZERO);
        chk("no read on write", dq_out, D1);
        host.cyc(1'b0, 1'b1, 4'hF, A, ZERO);
        @(negedge clk_sys) chk("abort kept", dq_out, merged);
        chk("read after write", dq_oe, ONES);
    endtask : t_abort

    // output enable acts with no clock edge
    task automatic t_oe();
        @(posedge clk_sys) host.output_enable_n <= 1'b1;
        #1 chk("oe gated off", dq_oe, ZERO);
        @(posedge clk_sys) host.output_enable_n <= 1'b0;
        #1 chk("oe gated on", dq_oe, ONES);
        host.cyc(1'b1, 1'b1, 4'hF, A, ZERO);
    endtask : t_oe

    // main sequence
    initial begin
        merged = (D1 & ~M1) | (D2 & M1);
        repeat (10) @(posedge clk_sys);
        chk("reset oe", dq_oe, ZERO);
        chk("reset out", dq_out, ZERO);
        rstn <= 1'b1;
        host.dwell();
        t_write_read();
        t_byte_merge();
        t_abort();
        t_oe();
        end_sim();
    end

    // watchdog
    initial begin
        #2000;
        mismatches++;
        end_sim();
    end
endmodule : late_write_sync_sram_core_tb_top
